// File: verilog/tvsmn_params.svh
// Register offsets, field layouts, masks and reset values for the timing block
`ifndef TVSMN_PARAMS_SVH
`define TVSMN_PARAMS_SVH

// Register offsets (byte addresses)
`define TVSMN_OFS_VSYNC 20'hE0014
`define TVSMN_OFS_BORDER 20'hE0020
`define TVSMN_OFS_SHIFT 20'hE0028
`define TVSMN_OFS_DATA_M1 20'hE0030
`define TVSMN_OFS_DATA_N1 20'hE0034
`define TVSMN_OFS_DATA_M2 20'hE0038
`define TVSMN_OFS_DATA_N2 20'hE003C
`define TVSMN_OFS_LINK_M1 20'hE0040
`define TVSMN_OFS_LINK_N1 20'hE0044
`define TVSMN_OFS_LINK_M2 20'hE0048
`define TVSMN_OFS_LINK_N2 20'hE004C
`define TVSMN_OFS_PKT_CTL 20'hE0200

// Writable-bit masks; all other bits are reserved and read zero
`define TVSMN_MASK_VSYNC 32'h1FFF1FFF
`define TVSMN_MASK_BORDER 32'h00FFFFFF
`define TVSMN_MASK_SHIFT 32'h00001FFF
`define TVSMN_MASK_DATA_M 32'h7EFFFFFF
`define TVSMN_MASK_RATIO 32'h00FFFFFF
`define TVSMN_MASK_PKT_CTL 32'hE3F8000F

// Reset values
`define TVSMN_RST_ZERO 32'h00000000
`define TVSMN_RST_PKT_CTL 32'h20000000

// Field positions
`define TVSMN_VS_END_MSB 28
`define TVSMN_VS_END_LSB 16
`define TVSMN_VS_START_MSB 12
`define TVSMN_VS_START_LSB 0
`define TVSMN_TU_MSB 30
`define TVSMN_TU_LSB 25
`define TVSMN_RATIO_MSB 23
`define TVSMN_RED_MSB 23
`define TVSMN_RED_LSB 16
`define TVSMN_GRN_MSB 15
`define TVSMN_GRN_LSB 8
`define TVSMN_BLU_MSB 7
`define TVSMN_BLU_LSB 0
`define TVSMN_SHIFT_MSB 12

`endif

// File: verilog/tvsmn_pkg.sv
// Types shared by the transcoder sync, border and M/N ratio block
`default_nettype none
package tvsmn_pkg;

   // Colour depth of the transcoder, per component
   typedef enum logic [1:0] {
      TVSMN_BPC_6,
      TVSMN_BPC_8,
      TVSMN_BPC_10,
      TVSMN_BPC_12
   } tvsmn_bpc_e;

   // One M/N ratio set (data pair with transfer unit, link pair)
   typedef struct packed {
      logic [5:0] tu_size;
      logic [23:0] data_m;
      logic [23:0] data_n;
      logic [23:0] link_m;
      logic [23:0] link_n;
   } tvsmn_ratio_s;

endpackage : tvsmn_pkg
`default_nettype wire

// File: verilog/tvsmn_core.sv
// Transcoder vertical sync, border colour and double-buffered M/N block
//
// Overview of operation
// RULE_01 - Sync end field sits at bits 28:16, absolute line from active start.
// RULE_02 - Sync start field sits at bits 12:0, first active line is zero.
// RULE_03 - Interlaced modes halve the sync start and end for each field.
// RULE_04 - Per-field sync positions ignore the inserted half lines.
// RULE_05 - Border regions output the 8-bit red, green, blue border colour.
// RULE_06 - Border components padded or truncated for non 8-bit colour depth.
// RULE_07 - Second-field sync shift is used only in interlaced modes.
// RULE_08 - Shift only in interlaced second field; else sync starts at hsync.
// RULE_09 - Software sets shift to hsync start minus half the horizontal total.
// RULE_10 - Data M holds transfer unit size minus one at bits 30:25.
// RULE_11 - Data M and N are 24-bit values for the differential accumulator.
// RULE_12 - Link M values go out in the main stream attributes.
// RULE_13 - Link N values go out in stream attributes and the VB-ID.
// RULE_14 - All M/N registers double-buffered, copied at vertical blank start.
// RULE_15 - Writing a set's link N register arms that whole set's update.
// RULE_16 - First set serves high power rate, second set low power rate.
// RULE_17 - Software programs both sets before switching refresh rates.
// RULE_18 - Software derives link and data ratios from dot and symbol clocks.
// RULE_19 - Packet control writes act immediately; reset value 20000000h.
// RULE_20 - Reserved bits ignore writes and read back as zero.
`timescale 1ns/1ps
`default_nettype none
`include "tvsmn_params.svh"

module tvsmn_core #(
   parameter int ADDR_W = 20,
   parameter int POS_W = 13
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Register access port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   // Raster position and mode from the timing counters
   input wire logic [POS_W-1:0] line_i,
   input wire logic [POS_W-1:0] pixel_i,
   input wire logic [POS_W-1:0] hsync_start_i,
   input wire logic interlaced_i,
   input wire logic second_field_i,
   input wire logic vblank_start_i,
   input wire logic border_i,
   input wire tvsmn_pkg::tvsmn_bpc_e bpc_i,
   input wire logic low_rate_i,
   // Sync and border pixel outputs
   output logic vsync_o,
   output logic border_valid_o,
   output logic [11:0] border_red_o,
   output logic [11:0] border_green_o,
   output logic [11:0] border_blue_o,
   // Active ratio outputs and packet control
   output logic [5:0] transfer_unit_size_o,
   output logic [23:0] accum_data_m_o,
   output logic [23:0] accum_data_n_o,
   output logic [23:0] msa_link_m_o,
   output logic [23:0] msa_link_n_o,
   output logic [23:0] vbid_link_n_o,
   output logic [31:0] video_packet_control_o
);
   import tvsmn_pkg::*;

   // Whole module state in one record
   typedef struct packed {
      // Software-visible registers, reserved bits held at zero
      logic [31:0] vertical_sync_position;
      logic [31:0] border_colour;
      logic [31:0] second_field_sync_shift;
      logic [31:0] data_ratio_m_first;
      logic [31:0] data_ratio_n_first;
      logic [31:0] data_ratio_m_second;
      logic [31:0] data_ratio_n_second;
      logic [31:0] link_ratio_m_first;
      logic [31:0] link_ratio_n_first;
      logic [31:0] link_ratio_m_second;
      logic [31:0] link_ratio_n_second;
      logic [31:0] video_packet_control;

      // Active ratio sets and their arm flags
      tvsmn_ratio_s active_first;
      tvsmn_ratio_s active_second;
      logic armed_first;
      logic armed_second;

      // Output staging; every port but video_packet_control_o reads one of these flops
      logic [31:0] rdata;
      logic vsync;
      logic border_valid;
      logic [11:0] border_red;
      logic [11:0] border_green;
      logic [11:0] border_blue;
      logic [5:0] tu_size;
      logic [23:0] data_m;
      logic [23:0] data_n;
      logic [23:0] link_m;
      logic [23:0] link_n;
   } tvsmn_state_s;

   tvsmn_state_s state_reg;
   tvsmn_state_s state_next;

   // Fit one 8-bit component to the transcoder depth, low aligned: six
   // bits drop the two low bits, ten and twelve pad zeros underneath
   function automatic logic [11:0] tvsmn_depth(input logic [7:0] comp,
                                               input tvsmn_bpc_e bpc);
      logic [11:0] res;
      res = 12'h000;
      case (bpc)
         TVSMN_BPC_6: res = {6'h00, comp[7:2]}; // Drop low bits [RULE_06]
         TVSMN_BPC_8: res = {4'h0, comp};
         TVSMN_BPC_10: res = {2'h0, comp, 2'h0}; // Zero pad [RULE_06]
         TVSMN_BPC_12: res = {comp, 4'h0};
         default: res = {4'h0, comp};
      endcase
      return res;
   endfunction : tvsmn_depth

   // Gather a staged set into its active form
   function automatic tvsmn_ratio_s tvsmn_pack(input logic [31:0] dm,
                                              input logic [31:0] dn,
                                              input logic [31:0] lm,
                                              input logic [31:0] ln);
      tvsmn_ratio_s s;
      s.tu_size = dm[`TVSMN_TU_MSB:`TVSMN_TU_LSB]; // Size minus one [RULE_10]
      s.data_m = dm[`TVSMN_RATIO_MSB:0]; // [RULE_11]
      s.data_n = dn[`TVSMN_RATIO_MSB:0]; // [RULE_11]
      s.link_m = lm[`TVSMN_RATIO_MSB:0];
      s.link_n = ln[`TVSMN_RATIO_MSB:0];
      return s;
   endfunction : tvsmn_pack

   // Per-field sync lines and the pixel where sync moves
   logic [12:0] vs_start_raw;
   logic [12:0] vs_end_raw;
   logic [12:0] vs_start_line;
   logic [12:0] vs_stop_line;
   logic [12:0] vs_edge_pixel;
   logic shift_used;

   // The line input counts whole lines only, so the halved figures never
   // include the half lines that interlaced timing inserts [RULE_04]
   always_comb begin
      vs_start_raw = state_reg.vertical_sync_position
                     [`TVSMN_VS_START_MSB:`TVSMN_VS_START_LSB]; // [RULE_02]
      vs_end_raw = state_reg.vertical_sync_position
                   [`TVSMN_VS_END_MSB:`TVSMN_VS_END_LSB]; // [RULE_01]
      if (interlaced_i) begin
         vs_start_line = {1'b0, vs_start_raw[12:1]}; // [RULE_03]
         vs_stop_line = {1'b0, vs_end_raw[12:1]}; // [RULE_03]
      end else begin
         vs_start_line = vs_start_raw;
         vs_stop_line = vs_end_raw;
      end
      // Sync ends after the whole end line, so stop one line later
      vs_stop_line = vs_stop_line + 13'h0001;
      shift_used = interlaced_i & second_field_i; // [RULE_07] [RULE_08]
      if (shift_used) begin
         vs_edge_pixel = state_reg.second_field_sync_shift
                         [`TVSMN_SHIFT_MSB:0]; // [RULE_08]
      end else begin
         vs_edge_pixel = hsync_start_i[12:0]; // [RULE_08]
      end
   end

   // Register decode, double buffering and output staging
   always_comb begin
      logic [31:0] wd;
      logic hit_ln1;
      logic hit_ln2;
      tvsmn_ratio_s sel;
      wd = reg_wdata_i;
      hit_ln1 = 1'b0;
      hit_ln2 = 1'b0;
      // Default pick keeps the selection defined on every path
      sel = state_reg.active_first;
      state_next = state_reg;

      // Writes keep only the defined bits [RULE_20]
      if (reg_wr_i) begin
         case (reg_addr_i)
            `TVSMN_OFS_VSYNC:
               state_next.vertical_sync_position = wd & `TVSMN_MASK_VSYNC;
            `TVSMN_OFS_BORDER:
               state_next.border_colour = wd & `TVSMN_MASK_BORDER;
            `TVSMN_OFS_SHIFT:
               state_next.second_field_sync_shift = wd & `TVSMN_MASK_SHIFT;
            `TVSMN_OFS_DATA_M1:
               state_next.data_ratio_m_first = wd & `TVSMN_MASK_DATA_M;
            `TVSMN_OFS_DATA_N1:
               state_next.data_ratio_n_first = wd & `TVSMN_MASK_RATIO;
            `TVSMN_OFS_DATA_M2:
               state_next.data_ratio_m_second = wd & `TVSMN_MASK_DATA_M;
            `TVSMN_OFS_DATA_N2:
               state_next.data_ratio_n_second = wd & `TVSMN_MASK_RATIO;
            `TVSMN_OFS_LINK_M1:
               state_next.link_ratio_m_first = wd & `TVSMN_MASK_RATIO;
            `TVSMN_OFS_LINK_N1: begin
               state_next.link_ratio_n_first = wd & `TVSMN_MASK_RATIO;
               hit_ln1 = 1'b1; // [RULE_15]
            end
            `TVSMN_OFS_LINK_M2:
               state_next.link_ratio_m_second = wd & `TVSMN_MASK_RATIO;
            `TVSMN_OFS_LINK_N2: begin
               state_next.link_ratio_n_second = wd & `TVSMN_MASK_RATIO;
               hit_ln2 = 1'b1; // [RULE_15]
            end
            `TVSMN_OFS_PKT_CTL: // No staging copy, acts at once [RULE_19]
               state_next.video_packet_control = wd & `TVSMN_MASK_PKT_CTL;
            default: ;
         endcase
      end

      // Read data, unmapped addresses and reserved bits read zero [RULE_20]
      state_next.rdata = 32'h00000000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `TVSMN_OFS_VSYNC:
               state_next.rdata = state_reg.vertical_sync_position;
            `TVSMN_OFS_BORDER:
               state_next.rdata = state_reg.border_colour;
            `TVSMN_OFS_SHIFT:
               state_next.rdata = state_reg.second_field_sync_shift;
            `TVSMN_OFS_DATA_M1:
               state_next.rdata = state_reg.data_ratio_m_first;
            `TVSMN_OFS_DATA_N1:
               state_next.rdata = state_reg.data_ratio_n_first;
            `TVSMN_OFS_DATA_M2:
               state_next.rdata = state_reg.data_ratio_m_second;
            `TVSMN_OFS_DATA_N2:
               state_next.rdata = state_reg.data_ratio_n_second;
            `TVSMN_OFS_LINK_M1:
               state_next.rdata = state_reg.link_ratio_m_first;
            `TVSMN_OFS_LINK_N1:
               state_next.rdata = state_reg.link_ratio_n_first;
            `TVSMN_OFS_LINK_M2:
               state_next.rdata = state_reg.link_ratio_m_second;
            `TVSMN_OFS_LINK_N2:
               state_next.rdata = state_reg.link_ratio_n_second;
            `TVSMN_OFS_PKT_CTL:
               state_next.rdata = state_reg.video_packet_control;
            default: state_next.rdata = 32'h00000000;
         endcase
      end

      // Armed sets copy at blank start; copies use the values held before
      // this edge, so a link N write landing with the blank pulse stays armed
      if (vblank_start_i && state_reg.armed_first) begin
         state_next.active_first = tvsmn_pack(state_reg.data_ratio_m_first,
            state_reg.data_ratio_n_first, state_reg.link_ratio_m_first,
            state_reg.link_ratio_n_first); // [RULE_14]
      end
      if (vblank_start_i && state_reg.armed_second) begin
         state_next.active_second = tvsmn_pack(state_reg.data_ratio_m_second,
            state_reg.data_ratio_n_second, state_reg.link_ratio_m_second,
            state_reg.link_ratio_n_second); // [RULE_14]
      end
      // Arm set wins over the clear by the blank pulse
      if (hit_ln1) begin
         state_next.armed_first = 1'b1; // [RULE_15]
      end else if (vblank_start_i) begin
         state_next.armed_first = 1'b0; // [RULE_14]
      end
      if (hit_ln2) begin
         state_next.armed_second = 1'b1; // [RULE_15]
      end else if (vblank_start_i) begin
         state_next.armed_second = 1'b0; // [RULE_14]
      end

      // Rate choice comes from the upstream stream attributes [RULE_16]
      sel = low_rate_i ? state_reg.active_second : state_reg.active_first;
      state_next.tu_size = sel.tu_size; // [RULE_10]
      state_next.data_m = sel.data_m; // [RULE_11]
      state_next.data_n = sel.data_n; // [RULE_11]
      state_next.link_m = sel.link_m; // [RULE_12]
      state_next.link_n = sel.link_n; // [RULE_13]

      // Vertical sync edges at the chosen pixel of the start and stop lines;
      // start is tested first, so it wins if both lines coincide
      if (line_i[12:0] == vs_start_line &&
          pixel_i[12:0] == vs_edge_pixel) begin
         state_next.vsync = 1'b1; // [RULE_02] [RULE_03]
      end else if (line_i[12:0] == vs_stop_line &&
                   pixel_i[12:0] == vs_edge_pixel) begin
         state_next.vsync = 1'b0; // [RULE_01] [RULE_03]
      end

      // Border pixels, scaled to the current depth
      state_next.border_valid = border_i; // [RULE_05]
      state_next.border_red = tvsmn_depth(
         state_reg.border_colour[`TVSMN_RED_MSB:`TVSMN_RED_LSB], bpc_i);
      state_next.border_green = tvsmn_depth(
         state_reg.border_colour[`TVSMN_GRN_MSB:`TVSMN_GRN_LSB], bpc_i);
      state_next.border_blue = tvsmn_depth(
         state_reg.border_colour[`TVSMN_BLU_MSB:`TVSMN_BLU_LSB], bpc_i);
      if (!border_i) begin
         // Keep colour lanes quiet outside the border to ease debug
         state_next.border_red = 12'h000;
         state_next.border_green = 12'h000;
         state_next.border_blue = 12'h000;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_reg <= '0;
         state_reg.video_packet_control <= `TVSMN_RST_PKT_CTL; // [RULE_19]
      end else begin
         state_reg <= state_next;
      end
   end

   // Every output is a flop of the state record
   assign reg_rdata_o = state_reg.rdata;
   assign vsync_o = state_reg.vsync;
   assign border_valid_o = state_reg.border_valid;
   assign border_red_o = state_reg.border_red;
   assign border_green_o = state_reg.border_green;
   assign border_blue_o = state_reg.border_blue;
   assign transfer_unit_size_o = state_reg.tu_size;
   assign accum_data_m_o = state_reg.data_m;
   assign accum_data_n_o = state_reg.data_n;
   assign msa_link_m_o = state_reg.link_m; // [RULE_12]
   assign msa_link_n_o = state_reg.link_n; // [RULE_13]
   assign vbid_link_n_o = state_reg.link_n; // [RULE_13]
   assign video_packet_control_o = state_reg.video_packet_control;

endmodule : tvsmn_core
`default_nettype wire

// File: verification/tvsmn_assertions.sv
// Port-level property checker for the sync, border and ratio block
`timescale 1ns/1ps
`default_nettype none
`include "tvsmn_params.svh"
module tvsmn_assertions (
   // Clock, reset and register port
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [19:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic [31:0] reg_rdata_o,
   // Raster inputs and block outputs
   input wire logic [12:0] pixel_i,
   input wire logic [12:0] hsync_start_i,
   input wire logic interlaced_i,
   input wire logic second_field_i,
   input wire logic vblank_start_i,
   input wire logic border_i,
   input wire tvsmn_pkg::tvsmn_bpc_e bpc_i,
   input wire logic low_rate_i,
   input wire logic vsync_o,
   input wire logic border_valid_o,
   input wire logic [11:0] border_red_o,
   input wire logic [11:0] border_green_o,
   input wire logic [11:0] border_blue_o,
   input wire logic [23:0] accum_data_m_o,
   input wire logic [23:0] msa_link_n_o,
   input wire logic [23:0] vbid_link_n_o,
   input wire logic [31:0] video_packet_control_o
);
   import tvsmn_pkg::*;
   // Single clock domain, so one default clock and disable serve all
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_pkt_reserved: assert property (
      reg_rd_i && reg_addr_i == `TVSMN_OFS_PKT_CTL |=>
      (reg_rdata_o & ~`TVSMN_MASK_PKT_CTL) == 32'h00000000)
      else $error("reserved packet control bits read nonzero");
   a_pkt_immediate: assert property (
      reg_wr_i && reg_addr_i == `TVSMN_OFS_PKT_CTL |=>
      video_packet_control_o == ($past(reg_wdata_i) & `TVSMN_MASK_PKT_CTL))
      else $error("packet control write not applied at once");
   a_vbid_copy: assert property (vbid_link_n_o == msa_link_n_o)
      else $error("link N differs between attribute and VB-ID paths");
   a_border_outside: assert property (
      !border_i |=> !border_valid_o && border_red_o == 12'h000 &&
      border_green_o == 12'h000 && border_blue_o == 12'h000)
      else $error("border colour driven outside border");
   a_border_six: assert property (
      border_i && bpc_i == TVSMN_BPC_6 |=>
      border_red_o[11:6] == 6'h00 && border_green_o[11:6] == 6'h00)
      else $error("six-bit border colour not truncated");
   a_border_ten: assert property (
      border_i && bpc_i == TVSMN_BPC_10 |=>
      border_green_o[1:0] == 2'h0 && border_blue_o[11:10] == 2'h0)
      else $error("ten-bit border colour not padded");
   a_ratio_hold: assert property (
      $changed(accum_data_m_o) |-> $past(vblank_start_i, 2) ||
      $past(low_rate_i) != $past(low_rate_i, 2))
      else $error("active ratio changed away from vertical blank");
   a_sync_edge: assert property (
      $changed(vsync_o) && !$past(interlaced_i && second_field_i) |->
      $past(pixel_i) == $past(hsync_start_i))
      else $error("vertical sync moved off the horizontal sync pixel");
endmodule : tvsmn_assertions
`default_nettype wire

// File: verification/tvsmn_raster.sv
// Raster counter model standing in for the upstream display pipe
`timescale 1ns/1ps
`default_nettype none
module tvsmn_raster #(
   parameter int HTOT = 16,
   parameter int VTOT = 12,
   parameter int VACT = 8,
   parameter int HSS = 12
) (
   // Clock, reset, mode and raster position
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic interlaced_i,
   output logic [12:0] line_o,
   output logic [12:0] pixel_o,
   output logic [12:0] hsync_start_o,
   output logic second_field_o,
   output logic vblank_start_o,
   output logic border_o
);
   // Counts whole lines only; moves on the falling edge, clear of sampling
   always @(negedge clk_sys_i) begin
      if (rst_i) begin
         pixel_o <= 13'h0000;
         line_o <= 13'h0000;
         second_field_o <= 1'b0;
      end else if (pixel_o != 13'(HTOT - 1)) begin
         pixel_o <= pixel_o + 13'h0001;
      end else begin
         pixel_o <= 13'h0000;
         line_o <= line_o + 13'h0001;
         if (line_o == 13'(VTOT - 1)) begin
            line_o <= 13'h0000;
            second_field_o <= interlaced_i & ~second_field_o;
         end
      end
   end
   // Fixed mode: two border pixels on each active line
   assign hsync_start_o = 13'(HSS);
   assign vblank_start_o = line_o == 13'(VACT) && pixel_o == 13'h0000;
   assign border_o = line_o < 13'(VACT) && pixel_o >= 13'h000A
      && pixel_o < 13'h000C;
endmodule : tvsmn_raster
`default_nettype wire

// File: verification/tvsmn_core_test.sv
// Self-checking bench for the sync, border and ratio block
`timescale 1ns/1ps
`default_nettype none
`include "tvsmn_params.svh"
module tvsmn_core_test;
   import tvsmn_pkg::*;
   `define CHK(n, e, g) check(n, 32'(e), 32'(g))
   typedef struct packed {logic [19:0] a; logic [31:0] r;
      logic [31:0] w; logic [31:0] e;} tvsmn_row_s;
   localparam int HSS = 12;
   localparam int HTOT = 16;
   localparam logic [31:0] W = 32'hFFFFFFFF;
   localparam logic [31:0] Z = 32'h00000000;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [19:0] reg_addr_i = 20'h00000;
   logic [31:0] reg_wdata_i = 32'h00000000;
   logic interlaced_i = 1'b0;
   logic low_rate_i = 1'b0;
   tvsmn_bpc_e bpc_i = TVSMN_BPC_8;
   logic [31:0] reg_rdata_o, video_packet_control_o, q;
   logic [12:0] line_i, pixel_i, hsync_start_i, ln, px;
   logic second_field_i, vblank_start_i, border_i, vsync_o, border_valid_o;
   logic [11:0] border_red_o, border_green_o, border_blue_o;
   logic [5:0] transfer_unit_size_o;
   logic [23:0] accum_data_m_o, accum_data_n_o, msa_link_m_o;
   logic [23:0] msa_link_n_o, vbid_link_n_o;
   int fail_count = 0;
   int tests_run = 0;
   // Address, reset value, value written, value read back
   tvsmn_row_s rows [13] = '{'{`TVSMN_OFS_VSYNC, Z, W, `TVSMN_MASK_VSYNC},
      '{`TVSMN_OFS_BORDER, Z, W, `TVSMN_MASK_BORDER},
      '{`TVSMN_OFS_SHIFT, Z, W, `TVSMN_MASK_SHIFT},
      '{`TVSMN_OFS_DATA_M1, Z, W, `TVSMN_MASK_DATA_M},
      '{`TVSMN_OFS_DATA_N1, Z, W, `TVSMN_MASK_RATIO},
      '{`TVSMN_OFS_LINK_M1, Z, W, `TVSMN_MASK_RATIO},
      '{`TVSMN_OFS_LINK_N1, Z, W, `TVSMN_MASK_RATIO},
      '{`TVSMN_OFS_DATA_M2, Z, W, `TVSMN_MASK_DATA_M},
      '{`TVSMN_OFS_DATA_N2, Z, W, `TVSMN_MASK_RATIO},
      '{`TVSMN_OFS_LINK_M2, Z, W, `TVSMN_MASK_RATIO},
      '{`TVSMN_OFS_LINK_N2, Z, W, `TVSMN_MASK_RATIO},
      '{`TVSMN_OFS_PKT_CTL, `TVSMN_RST_PKT_CTL, W, `TVSMN_MASK_PKT_CTL},
      '{20'hE0024, Z, W, Z}};
   tvsmn_core uut (.clk_sys_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
      .reg_wdata_i, .reg_rdata_o, .line_i, .pixel_i, .hsync_start_i,
      .interlaced_i, .second_field_i, .vblank_start_i, .border_i, .bpc_i,
      .low_rate_i, .vsync_o, .border_valid_o, .border_red_o, .border_green_o,
      .border_blue_o, .transfer_unit_size_o, .accum_data_m_o, .accum_data_n_o,
      .msa_link_m_o, .msa_link_n_o, .vbid_link_n_o, .video_packet_control_o);
   tvsmn_raster #(.HTOT(HTOT), .HSS(HSS)) pipe (.clk_sys_i, .rst_i,
      .interlaced_i, .line_o(line_i), .pixel_o(pixel_i),
      .hsync_start_o(hsync_start_i), .second_field_o(second_field_i),
      .vblank_start_o(vblank_start_i), .border_o(border_i));
   // 200 MHz clock
   always #2.5 clk_sys_i = ~clk_sys_i;
   task automatic check(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : check
   // Bus tasks start and end on a falling edge; strobes rest a cycle
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_sys_i) reg_wr_i = 1'b0;
      @(negedge clk_sys_i);
   endtask : wr
   task automatic rd(input logic [19:0] a, output logic [31:0] d);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_sys_i) reg_rd_i = 1'b0;
      d = reg_rdata_o;
      @(negedge clk_sys_i);
   endtask : rd
   // Ratio outputs settle two edges after the blanking pulse
   task automatic wait_vblank();
      for (int i = 0; i < 400; i++) begin
         @(posedge clk_sys_i);
         if (vblank_start_i) break;
      end
      repeat (3) @(negedge clk_sys_i);
   endtask : wait_vblank
   // Pixel inputs hold until the falling edge, so capture them at the edge
   task automatic edge_wait(input logic up, input logic fld);
      for (int i = 0; i < 20; i++) begin
         if (up) @(posedge vsync_o);
         else @(negedge vsync_o);
         if (second_field_i === fld) break;
      end
      ln = line_i;
      px = pixel_i;
      @(negedge clk_sys_i);
   endtask : edge_wait
   function automatic logic [11:0] scale(logic [7:0] c, int b);
      case (b)
         0: return {6'h00, c[7:2]};
         1: return {4'h0, c};
         2: return {2'h0, c, 2'h0};
         default: return {c, 4'h0};
      endcase
   endfunction : scale
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // Watchdog sized well past the expected few thousand cycles
   initial begin
      repeat (30000) @(posedge clk_sys_i);
      fail_count++;
      wrap_up();
   end
   // Main sequence: register table, then buffering, border and sync cases
   initial begin
      repeat (10) @(negedge clk_sys_i);
      rst_i = 1'b0;
      `CHK("pkt_out", `TVSMN_RST_PKT_CTL, video_packet_control_o);
      foreach (rows[i]) begin
         rd(rows[i].a, q);
         `CHK("reset_val", rows[i].r, q);
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, q);
         `CHK("read_back", rows[i].e, q);
      end
      wait_vblank();
      `CHK("tu_size", 6'h3F, transfer_unit_size_o);
      wr(`TVSMN_OFS_DATA_M1, 32'h7E123456);
      wr(`TVSMN_OFS_DATA_N1, 32'h00654321);
      wr(`TVSMN_OFS_LINK_M1, 32'h00111222);
      wait_vblank();
      `CHK("unarmed", 24'hFFFFFF, accum_data_m_o);
      wr(`TVSMN_OFS_LINK_N1, 32'h00333444);
      `CHK("pre_blank", 24'hFFFFFF, accum_data_m_o);
      wait_vblank();
      `CHK("data_m", 24'h123456, accum_data_m_o);
      `CHK("data_n", 24'h654321, accum_data_n_o);
      `CHK("link_m", 24'h111222, msa_link_m_o);
      `CHK("vbid_n", 24'h333444, vbid_link_n_o);
      wr(`TVSMN_OFS_DATA_M2, 32'h02111111);
      wr(`TVSMN_OFS_LINK_N2, 32'h00555555);
      wait_vblank();
      low_rate_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      `CHK("tu_low", 6'h01, transfer_unit_size_o);
      `CHK("link_n_low", 24'h555555, msa_link_n_o);
      low_rate_i = 1'b0;
      wr(`TVSMN_OFS_BORDER, 32'h00A1B2C3);
      for (int b = 0; b < 4; b++) begin
         bpc_i = tvsmn_bpc_e'(b);
         repeat (20) @(negedge clk_sys_i);
         for (int i = 0; i < 400 && !border_valid_o; i++) @(negedge clk_sys_i);
         `CHK("red", scale(8'hA1, b), border_red_o);
         `CHK("green", scale(8'hB2, b), border_green_o);
         `CHK("blue", scale(8'hC3, b), border_blue_o);
         `CHK("valid", 1'b1, border_valid_o);
      end
      wr(`TVSMN_OFS_VSYNC, 32'h000A0009);
      edge_wait(1'b1, 1'b0);
      `CHK("vs_start", 9, ln);
      edge_wait(1'b0, 1'b0);
      `CHK("vs_end", 11, ln);
      wr(`TVSMN_OFS_VSYNC, 32'h00140012);
      wr(`TVSMN_OFS_SHIFT, 32'(HSS - HTOT / 2));
      interlaced_i = 1'b1;
      edge_wait(1'b1, 1'b1);
      `CHK("field_line", 9, ln);
      `CHK("shift_px", HSS - HTOT / 2, px);
      edge_wait(1'b1, 1'b0);
      `CHK("first_px", HSS, px);
      `CHK("first_line", 9, ln);
      // Leave interlace while the second field runs, so the shift must idle
      edge_wait(1'b0, 1'b0);
      wr(`TVSMN_OFS_VSYNC, 32'h000A0009);
      while (!second_field_i) @(negedge clk_sys_i);
      interlaced_i = 1'b0;
      edge_wait(1'b1, 1'b1);
      `CHK("prog_px", HSS, px);
      `CHK("prog_line", 9, ln);
      wrap_up();
   end
endmodule : tvsmn_core_test
bind tvsmn_core tvsmn_assertions chk (.clk_sys_i, .rst_i, .reg_wr_i,
   .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .pixel_i,
   .hsync_start_i, .interlaced_i, .second_field_i, .vblank_start_i,
   .border_i, .bpc_i, .low_rate_i, .vsync_o, .border_valid_o, .border_red_o,
   .border_green_o, .border_blue_o, .accum_data_m_o, .msa_link_n_o,
   .vbid_link_n_o, .video_packet_control_o);
`default_nettype wire
